// File: logic/srv_consts.vh
`ifndef SRV_CONSTS_VH
`define SRV_CONSTS_VH

// register byte offsets
`define SRV_REG_CTRL      5'h00
`define SRV_REG_TRIM      5'h04
`define SRV_REG_SPEED     5'h08
`define SRV_REG_SCALE     5'h0c
`define SRV_REG_MOTION    5'h10
`define SRV_REG_STATUS    5'h14
`define SRV_REG_WIDTH     5'h18

// control field positions
`define SRV_CTRL_SERVO    0
`define SRV_CTRL_REST     1
`define SRV_CTRL_DIR      2

// motion field positions, right wheel sits 8 bits higher
`define SRV_MOT_ON        0
`define SRV_MOT_REV       1
`define SRV_MOT_SLOW      2
`define SRV_MOT_RIGHT     8

// reset values
`define SRV_CTRL_RST      3'h4
`define SRV_TRIM_RST      8'h80
`define SRV_SPEED_RST     7'h64
`define SRV_REDUCED_RST   7'h32
`define SRV_SCALE_RST     8'h32

// pulse figures in microseconds
`define SRV_STOP_US       13'h5dc
`define SRV_MIN_US        13'h3e8
`define SRV_MAX_US        13'h7d0
`define SRV_TRIM_MID      13'h080
`define SRV_TRIM_STEP_US  13'h001
`define SRV_PCT_FULL      7'h64
`define SRV_PCT_DIV       14'h000a

// timing
`define SRV_CLK_MHZ       100
`define SRV_TICK_US       1
`define SRV_FRAME_HZ      50
`define SRV_FRAME_US      (1000000 / `SRV_FRAME_HZ)
`define SRV_TICK_CYCLES   (`SRV_CLK_MHZ * `SRV_TICK_US)

// axi responses
`define SRV_RESP_OKAY     2'h0
`define SRV_RESP_SLVERR   2'h2

`endif

// File: logic/srv_channel.v
`timescale 1ns/1ps
`include "srv_consts.vh"

module srv_channel (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        frame_start,
  input  wire [14:0] us_count,
  input  wire        servo_mode,
  input  wire        rest_pulse,
  input  wire        motor_on,
  input  wire        motor_rev,
  input  wire        use_reduced,
  input  wire        dir_invert,
  input  wire [6:0]  speed,
  input  wire [6:0]  reduced,
  input  wire [7:0]  trim,
  input  wire [7:0]  scale,
  output reg         line_q,
  output reg  [12:0] width_q,
  output reg         active_q
);

  wire [6:0]  pct_raw;
  wire [6:0]  pct;
  wire [6:0]  scl;
  wire [13:0] prod;
  wire [13:0] delta_full;
  wire [12:0] delta;
  wire [12:0] center;
  wire        widen;
  wire [12:0] raw_width;
  wire [12:0] width_d;

  // percentages above full are held at full
  assign pct_raw = use_reduced ? reduced : speed;
  assign pct     = (pct_raw > `SRV_PCT_FULL) ? `SRV_PCT_FULL : pct_raw;
  assign scl     = (scale > {1'b0, `SRV_PCT_FULL}) ? `SRV_PCT_FULL : scale[6:0];

  // excursion scaling
  // excursion = scale% of 1000 us, times speed%
  assign prod       = {7'h00, scl} * {7'h00, pct};
  assign delta_full = prod / `SRV_PCT_DIV;
  assign delta      = motor_on ? delta_full[12:0] : 13'h0000;

  assign center = `SRV_STOP_US - `SRV_TRIM_MID * `SRV_TRIM_STEP_US
                + {5'h00, trim} * `SRV_TRIM_STEP_US;

  assign widen     = ~(motor_rev ^ dir_invert);
  assign raw_width = widen ? (center + delta) : (center - delta);

  assign width_d = (raw_width < `SRV_MIN_US) ? `SRV_MIN_US :
                   (raw_width > `SRV_MAX_US) ? `SRV_MAX_US : raw_width;

  // settings taken at frame start so a pulse is never cut short
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      width_q  <= `SRV_STOP_US;
      active_q <= 1'b0;
      line_q   <= 1'b0;
    end
    else
    begin
      if (frame_start)
      begin
        width_q  <= width_d;
        active_q <= servo_mode & (motor_on | rest_pulse);
      end
      line_q <= active_q & ({2'b00, us_count} < width_q);
    end
  end

endmodule

// File: logic/srv_pulse_gen.v
`timescale 1ns/1ps
`include "srv_consts.vh"

// Function
// - each pulsing channel repeats its pulse fifty times per second.
// - pulse width stays within one to two milliseconds.
// - zero speed gives a nominal 1500 microsecond pulse.
// - wider pulse spins one way, narrower pulse spins the other way.
// - at default scale, half speed 1750 us, full speed 2000 us.
// - with rest pulsing on, stopped motors still get stop-width pulses.
// - by default a motor commanded off receives no pulses.
// - rest pulsing bit one keeps pulsing, zero restores default.
// - each wheel has an 8-bit stop trim, default 128.
// - excursion scale, default 50, rescales all speeds together.
// - direction bit zero reverses both servos, one restores default.
// - dc-motor speed settings drive the servo widths too.
// - separate open-drain left and right control lines.
// - speed and reduced speed are percentages, 100 is fastest.

module srv_pulse_gen #(
  parameter TICK_CYCLES = `SRV_TICK_CYCLES,
  parameter FRAME_US    = `SRV_FRAME_US
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        left_servo_in,
  output wire        left_servo_out,
  output wire        left_servo_oe_n,
  input  wire        right_servo_in,
  output wire        right_servo_out,
  output wire        right_servo_oe_n
);

  reg  [2:0]  ctrl_q;
  reg  [7:0]  trim_l_q;
  reg  [7:0]  trim_r_q;
  reg  [6:0]  speed_q;
  reg  [6:0]  reduced_q;
  reg  [7:0]  scale_q;
  reg  [15:0] motion_q;
  reg         aw_have_q;
  reg  [4:0]  aw_addr_q;
  reg         w_have_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg  [31:0] rdata_d;
  reg         rmapped_d;
  reg  [31:0] old_d;
  reg         wmapped_d;
  reg  [31:0] merged_d;
  reg  [15:0] tick_q;
  reg  [14:0] us_cnt_q;
  reg  [2:0]  lpin_q;
  reg  [2:0]  rpin_q;
  reg         lpin_lvl_q;
  reg         rpin_lvl_q;
  wire        tick_end;
  wire        frame_start;
  wire        do_write;
  wire        left_line;
  wire        right_line;
  wire [12:0] left_width;
  wire [12:0] right_width;
  wire        left_active;
  wire        right_active;
  integer     i;

  // write address and data may come in either order
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write      = aw_have_q & w_have_q & ~s_axi_bvalid;

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_q <= 1'b0;
    end
  end

  // current contents of the addressed writable register
  always @*
  begin
    old_d     = 32'h00000000;
    wmapped_d = 1'b1;
    case ({aw_addr_q[4:2], 2'b00})
      `SRV_REG_CTRL:   old_d = {29'h0, ctrl_q};
      `SRV_REG_TRIM:   old_d = {16'h0, trim_r_q, trim_l_q};
      `SRV_REG_SPEED:  old_d = {17'h0, reduced_q, 1'b0, speed_q};
      `SRV_REG_SCALE:  old_d = {24'h0, scale_q};
      `SRV_REG_MOTION: old_d = {16'h0, motion_q};
      default:         wmapped_d = 1'b0;
    endcase
    for (i = 0; i < 4; i = i + 1)
      merged_d[i*8 +: 8] = w_strb_q[i] ? w_data_q[i*8 +: 8] : old_d[i*8 +: 8];
  end

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q       <= `SRV_CTRL_RST;
      trim_l_q     <= `SRV_TRIM_RST;
      trim_r_q     <= `SRV_TRIM_RST;
      speed_q      <= `SRV_SPEED_RST;
      reduced_q    <= `SRV_REDUCED_RST;
      scale_q      <= `SRV_SCALE_RST;
      motion_q     <= 16'h0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SRV_RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wmapped_d ? `SRV_RESP_OKAY : `SRV_RESP_SLVERR;
        case ({aw_addr_q[4:2], 2'b00})
          `SRV_REG_CTRL:
            ctrl_q <= merged_d[2:0];
          `SRV_REG_TRIM:
          begin
            trim_l_q <= merged_d[7:0];
            trim_r_q <= merged_d[15:8];
          end
          `SRV_REG_SPEED:
          begin
            speed_q   <= merged_d[6:0];
            reduced_q <= merged_d[14:8];
          end
          `SRV_REG_SCALE:
            scale_q <= merged_d[7:0];
          `SRV_REG_MOTION:
            motion_q <= merged_d[15:0] & 16'h0707;
          default:
            ctrl_q <= ctrl_q;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read side
  always @*
  begin
    rdata_d   = 32'h00000000;
    rmapped_d = 1'b1;
    case ({s_axi_araddr[4:2], 2'b00})
      `SRV_REG_CTRL:   rdata_d = {29'h0, ctrl_q};
      `SRV_REG_TRIM:   rdata_d = {16'h0, trim_r_q, trim_l_q};
      `SRV_REG_SPEED:  rdata_d = {17'h0, reduced_q, 1'b0, speed_q};
      `SRV_REG_SCALE:  rdata_d = {24'h0, scale_q};
      `SRV_REG_MOTION: rdata_d = {16'h0, motion_q};
      `SRV_REG_STATUS: rdata_d = {26'h0, rpin_lvl_q, lpin_lvl_q, right_line, left_line, right_active, left_active};
      `SRV_REG_WIDTH:  rdata_d = {3'h0, right_width, 3'h0, left_width};
      default:         rmapped_d = 1'b0;
    endcase
  end

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SRV_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_d;
        s_axi_rresp  <= rmapped_d ? `SRV_RESP_OKAY : `SRV_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // pin readback, shows a shorted or unpowered line that the drive bits cannot
  // a level counts only once the two late stages agree
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lpin_q     <= 3'h0;
      rpin_q     <= 3'h0;
      lpin_lvl_q <= 1'b0;
      rpin_lvl_q <= 1'b0;
    end
    else
    begin
      lpin_q <= {lpin_q[1:0], left_servo_in};
      rpin_q <= {rpin_q[1:0], right_servo_in};
      if (lpin_q[1] == lpin_q[2])
        lpin_lvl_q <= lpin_q[2];
      if (rpin_q[1] == rpin_q[2])
        rpin_lvl_q <= rpin_q[2];
    end
  end

  // microsecond tick and frame counter shared by both wheels
  assign tick_end    = (tick_q == TICK_CYCLES[15:0] - 16'h0001);
  assign frame_start = tick_end & (us_cnt_q == FRAME_US[14:0] - 15'h0001);

  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_q   <= 16'h0000;
      us_cnt_q <= 15'h0000;
    end
    else
    begin
      tick_q <= tick_end ? 16'h0000 : tick_q + 16'h0001;
      if (frame_start)
        us_cnt_q <= 15'h0000;
      else if (tick_end)
        us_cnt_q <= us_cnt_q + 15'h0001;
    end
  end

  srv_channel u_left (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .frame_start (frame_start),
    .us_count    (us_cnt_q),
    .servo_mode  (ctrl_q[`SRV_CTRL_SERVO]),
    .rest_pulse  (ctrl_q[`SRV_CTRL_REST]),
    .motor_on    (motion_q[`SRV_MOT_ON]),
    .motor_rev   (motion_q[`SRV_MOT_REV]),
    .use_reduced (motion_q[`SRV_MOT_SLOW]),
    .dir_invert  (~ctrl_q[`SRV_CTRL_DIR]),
    .speed       (speed_q),
    .reduced     (reduced_q),
    .trim        (trim_l_q),
    .scale       (scale_q),
    .line_q      (left_line),
    .width_q     (left_width),
    .active_q    (left_active)
  );

  srv_channel u_right (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .frame_start (frame_start),
    .us_count    (us_cnt_q),
    .servo_mode  (ctrl_q[`SRV_CTRL_SERVO]),
    .rest_pulse  (ctrl_q[`SRV_CTRL_REST]),
    .motor_on    (motion_q[`SRV_MOT_RIGHT + `SRV_MOT_ON]),
    .motor_rev   (motion_q[`SRV_MOT_RIGHT + `SRV_MOT_REV]),
    .use_reduced (motion_q[`SRV_MOT_RIGHT + `SRV_MOT_SLOW]),
    .dir_invert  (~ctrl_q[`SRV_CTRL_DIR]),
    .speed       (speed_q),
    .reduced     (reduced_q),
    .trim        (trim_r_q),
    .scale       (scale_q),
    .line_q      (right_line),
    .width_q     (right_width),
    .active_q    (right_active)
  );

  // open-drain lines
  // high is the external pull-up, so the pin is released during the pulse
  assign left_servo_out   = 1'b0;
  assign left_servo_oe_n  = left_line;
  assign right_servo_out  = 1'b0;
  assign right_servo_oe_n = right_line;

endmodule

// File: test/srv_pulse_gen_monitor.sv
`timescale 1ns/1ps
module srv_pulse_gen_monitor #(
  parameter TICK_CYCLES = 100,
  parameter FRAME_US    = 20000
) (
  input wire clock,
  input wire sys_rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire left_servo_out,
  input wire right_servo_out,
  input wire left_servo_oe_n
);
  localparam int FRAME = FRAME_US * TICK_CYCLES;
  logic [31:0] hi_q;
  logic [31:0] rc_q;
  logic        seen_q;
  logic        prev_q;

  // high run length and distance between rising edges
  always @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hi_q   <= 32'h0;
      rc_q   <= 32'h0;
      seen_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= left_servo_oe_n;
      hi_q   <= left_servo_oe_n ? hi_q + 32'h1 : 32'h0;
      rc_q   <= (left_servo_oe_n && !prev_q) ? 32'h1 : rc_q + 32'h1;
      seen_q <= seen_q | (left_servo_oe_n && !prev_q);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  AST_WR_RESP: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_RD_RESP: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  AST_OPEN_DRAIN: assert property (!left_servo_out && !right_servo_out)
    else $error("servo line driven high");
  AST_PULSE_MAX: assert property (hi_q <= 2000 * TICK_CYCLES)
    else $error("pulse longer than two ms");
  AST_PULSE_MIN: assert property ($fell(left_servo_oe_n) |-> hi_q >= 1000 * TICK_CYCLES)
    else $error("pulse shorter than one ms");
  AST_FRAME_RATE: assert property (left_servo_oe_n && !prev_q && seen_q |-> rc_q % FRAME == 0)
    else $error("pulse off the frame grid");
endmodule

bind srv_pulse_gen srv_pulse_gen_monitor #(.TICK_CYCLES(TICK_CYCLES), .FRAME_US(FRAME_US)) u_mon (
  .clock           (clock),
  .sys_rst         (sys_rst),
  .s_axi_awvalid   (s_axi_awvalid),
  .s_axi_awready   (s_axi_awready),
  .s_axi_wvalid    (s_axi_wvalid),
  .s_axi_wready    (s_axi_wready),
  .s_axi_bvalid    (s_axi_bvalid),
  .s_axi_arvalid   (s_axi_arvalid),
  .s_axi_arready   (s_axi_arready),
  .s_axi_rvalid    (s_axi_rvalid),
  .left_servo_out  (left_servo_out),
  .right_servo_out (right_servo_out),
  .left_servo_oe_n (left_servo_oe_n)
);

// File: test/srv_servo_model.sv
`timescale 1ns/1ps
module srv_servo_model (
  input  wire         clock,
  input  wire         line,
  output logic [31:0] width_cyc,
  output int          n_pulses
);
  logic [31:0] run_q = 32'h0;
  logic        prev_q = 1'b0;

  initial width_cyc = 32'h0;
  initial n_pulses = 0;

  always @(posedge clock)
  begin
    prev_q <= line;
    run_q  <= line ? run_q + 32'h1 : 32'h0;
    if (prev_q && !line)
    begin
      width_cyc <= run_q;
      n_pulses  <= n_pulses + 1;
    end
  end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int TICK  = 2;
  localparam int FUS   = 2500;
  localparam int FRAME = TICK * FUS;
  logic        clock         = 1'b0;
  logic        sys_rst       = 1'b1;
  logic [4:0]  s_axi_awaddr  = 5'h0;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b1;
  logic [4:0]  s_axi_araddr  = 5'h0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b1;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         left_servo_out, left_servo_oe_n, right_servo_out, right_servo_oe_n;
  wire         left_servo_in  = left_servo_oe_n ? 1'b1 : left_servo_out;
  wire         right_servo_in = right_servo_oe_n ? 1'b1 : right_servo_out;
  logic [31:0] lw, rw;
  int          ln, rn;
  int          errors     = 0;
  int          n_compared = 0;

  srv_pulse_gen #(.TICK_CYCLES(TICK), .FRAME_US(FUS)) dut (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .s_axi_awaddr     (s_axi_awaddr),
    .s_axi_awvalid    (s_axi_awvalid),
    .s_axi_awready    (s_axi_awready),
    .s_axi_wdata      (s_axi_wdata),
    .s_axi_wstrb      (s_axi_wstrb),
    .s_axi_wvalid     (s_axi_wvalid),
    .s_axi_wready     (s_axi_wready),
    .s_axi_bresp      (s_axi_bresp),
    .s_axi_bvalid     (s_axi_bvalid),
    .s_axi_bready     (s_axi_bready),
    .s_axi_araddr     (s_axi_araddr),
    .s_axi_arvalid    (s_axi_arvalid),
    .s_axi_arready    (s_axi_arready),
    .s_axi_rdata      (s_axi_rdata),
    .s_axi_rresp      (s_axi_rresp),
    .s_axi_rvalid     (s_axi_rvalid),
    .s_axi_rready     (s_axi_rready),
    .left_servo_in    (left_servo_in),
    .left_servo_out   (left_servo_out),
    .left_servo_oe_n  (left_servo_oe_n),
    .right_servo_in   (right_servo_in),
    .right_servo_out  (right_servo_out),
    .right_servo_oe_n (right_servo_oe_n)
  );
  srv_servo_model u_left (.clock(clock), .line(left_servo_in), .width_cyc(lw), .n_pulses(ln));
  srv_servo_model u_right (.clock(clock), .line(right_servo_in), .width_cyc(rw), .n_pulses(rn));

  initial forever #5 clock = ~clock;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready is settled at the falling edge, so it equals what the rising edge samples
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    logic t;
    logic [1:0] r;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(negedge clock);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      @(posedge clock);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end while (!(ad && wd));
    do
    begin
      @(negedge clock);
      t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
    end while (!t);
    check({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(negedge clock);
      t = s_axi_arready;
      @(posedge clock);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(negedge clock);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
    end while (!t);
    check(d, ed);
    check({30'h0, r}, {30'h0, er});
  endtask

  function automatic logic [12:0] exp_w(input logic [7:0] trim, input logic [6:0] pct, input logic [7:0] sc,
                                        input logic rev, input logic dir, input logic on);
    int p;
    int s;
    int w;
    p = (pct > 100) ? 100 : pct;
    s = (sc > 100) ? 100 : sc;
    w = 1500 + int'(trim) - 128;
    w = ((rev ^ !dir) == 1'b0) ? w + (on ? s * p / 10 : 0) : w - (on ? s * p / 10 : 0);
    w = (w < 1000) ? 1000 : ((w > 2000) ? 2000 : w);
    return w[12:0];
  endfunction

  task automatic print_verdict;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    // the whole run needs about sixteen frames
    repeat (18 * FRAME) @(posedge clock);
    errors++;
    print_verdict();
  end

  initial
  begin
    logic [31:0] rv [7] = '{32'h4, 32'h8080, 32'h3264, 32'h32, 32'h0, 32'h0, 32'h05dc05dc};
    logic [7:0]  tl, tr, sc;
    logic [6:0]  spd, red;
    logic [2:0]  ctrl;
    logic [31:0] mot;
    logic [12:0] el, er;
    int          n0;
    void'($urandom(32'h9acdbeba));
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    foreach (rv[i]) rd(5'(i * 4), rv[i], 2'h0);
    rd(5'h1c, 32'h0, 2'h2);
    wr(5'h14, 32'hf, 2'h2);
    s_axi_wstrb <= 4'h2;
    wr(5'h04, 32'h00003311, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(5'h04, 32'h00003380, 2'h0);
    repeat (2 * FRAME) @(posedge clock);
    check(ln + rn, 0);
    for (int i = 0; i < 6; i++)
    begin
      tl = 8'($urandom);
      tr = 8'($urandom);
      spd = 7'($urandom);
      red = 7'($urandom);
      sc = 8'($urandom % 128);
      ctrl = 3'($urandom) | 3'h1;
      mot = ($urandom & 32'h0606) | 32'h0101;
      // first pass: nominal full and half speed
      if (i == 0)
      begin
        {tl, tr, spd, red, sc, ctrl, mot} = {8'h80, 8'h80, 7'h64, 7'h32, 8'h32, 3'h5, 32'h0501};
      end
      // reversed sense guaranteed at least once
      if (i == 3)
        ctrl = 3'h1;
      if (i >= 4)
      begin
        mot = 32'h0;
        ctrl = (i == 4) ? 3'h7 : 3'h5;
      end
      wr(5'h00, {29'h0, ctrl}, 2'h0);
      wr(5'h04, {16'h0, tr, tl}, 2'h0);
      wr(5'h08, {17'h0, red, 1'b0, spd}, 2'h0);
      wr(5'h0c, {24'h0, sc}, 2'h0);
      wr(5'h10, mot, 2'h0);
      repeat (2 * FRAME) @(posedge clock);
      el = exp_w(tl, mot[2] ? red : spd, sc, mot[1], ctrl[2], mot[0]);
      er = exp_w(tr, mot[10] ? red : spd, sc, mot[9], ctrl[2], mot[8]);
      if (i < 5)
      begin
        check(lw, el * TICK);
        check(rw, er * TICK);
        rd(5'h18, {3'h0, er, 3'h0, el}, 2'h0);
        if (i == 4)
        begin
          // both rest pulses start together and last over a millisecond
          @(posedge left_servo_oe_n);
          repeat (8) @(posedge clock);
          rd(5'h14, 32'h3f, 2'h0);
        end
      end
      else
      begin
        n0 = ln + rn;
        repeat (FRAME) @(posedge clock);
        check(ln + rn, n0);
      end
    end
    print_verdict();
  end
endmodule
